// >>> sim/mat_host_model.sv
// Host-side model that drives mailbox accesses onto the tracker link.
module mat_host_model
  import mat_pkg::*;
(
  output mat_pkg::mat_link_type link_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial link_out = LINK_IDLE;

  // The odd start offset keeps link edges off the bus clock grid.
  task automatic start_frame();
    #7;
    link_out.frame_n = 1'b0;
    #100;
  endtask

  // The link clock only runs inside frames. Fields are inverted after the
  // hold time, so a design sampling late sees wrong values, not stale ones.
  task automatic access(input logic wr, input logic [4:0] idx);
    link_out.acc = 1'b1;
    link_out.wr = wr;
    link_out.idx = idx;
    #100;
    link_out.clk = 1'b1;
    #100;
    link_out.clk = 1'b0;
    link_out.acc = 1'b0;
    link_out.wr = ~wr;
    link_out.idx = ~idx;
  endtask

  task automatic end_frame();
    #100;
    link_out.frame_n = 1'b1;
    #100;
  endtask
endmodule // mat_host_model

// >>> sim/tb_top.sv
// Self-checking bench for the mailbox access tracker.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mat_pkg::*;

  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [9:0]   paddr = 10'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         stop_mode = 1'b0;
  logic         mbox_irq;
  mat_link_type link;
  int           error_cnt = 0;
  int           check_count = 0;
  int           cyc = 0;
  bit   [31:0]  m_wr, m_rd;
  bit           m_pend, m_hit, m_wen, m_ren, m_sen;
  int           m_mode;
  logic [31:0]  q;
  logic         e;

  mat_mailbox_tracker u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link),
    .stop_mode(stop_mode), .mbox_irq(mbox_irq));
  mat_host_model u_host (.link_out(link));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // Checking, bus and model tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the very edge where ready is seen high.
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_ctrl(input int m, input bit wen, input bit ren,
                          input bit sen);
    m_mode = m;
    m_wen = wen;
    m_ren = ren;
    m_sen = sen;
    {m_wr, m_rd, m_pend, m_hit} = '0;
    apb(1'b1, ADDR_CTRL, {26'h0, 1'b1, sen, ren, wen, 2'(m)});
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", q, {27'h0, sen, ren, wen, 2'(m)});
  endtask

  task automatic check_irq();
    @(negedge pclk);
    check("irq", {31'h0, mbox_irq},
          {31'h0, m_pend && (!stop_mode || m_sen)});
  endtask

  task automatic check_regs();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ADDR_WR_31_24 + 10'(4 * i), 32'h0);
      check("wflags", q, (m_wr >> (24 - 8 * i)) & 32'hff);
      apb(1'b0, ADDR_RD_31_24 + 10'(4 * i), 32'h0);
      check("rflags", q, (m_rd >> (24 - 8 * i)) & 32'hff);
      check("err", {31'h0, e}, 32'h0);
    end
  endtask

  task automatic host_acc(input bit w, input logic [4:0] i);
    u_host.access(w, i);
    if (w) m_wr[i] = 1'b1;
    else m_rd[i] = 1'b1;
    if ((w && m_wen) || (!w && m_ren)) begin
      if ((m_mode == 1 && i == 15) || (m_mode == 2 && i == 31)) m_pend = 1;
      if (m_mode == 0) m_hit = 1'b1;
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic end_frame();
    u_host.end_frame();
    m_pend = m_pend | m_hit;
    m_hit = 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(57999));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check_regs();
    apb(1'b0, 10'h3fc, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b1, ADDR_WR_7_0, 32'hff);
    check_regs();
    for (int m = 0; m < 4; m++) begin
      for (int en = 0; en < 4; en++) begin
        set_ctrl(m, en[0], en[1], 1'b0);
        u_host.start_frame();
        for (int k = 0; k < 6; k++) begin
          host_acc(1'($urandom_range(1, 0)), (k == 2) ? 5'd15 :
                   (k == 4) ? 5'd31 : 5'($urandom_range(31, 0)));
          check_irq();
        end
        check_regs();
        end_frame();
        check_irq();
        check_regs();
      end
    end
    for (int s = 0; s < 2; s++) begin
      set_ctrl(1, 1'b1, 1'b0, 1'(s));
      stop_mode <= 1'b1;
      u_host.start_frame();
      host_acc(1'b1, 5'd15);
      check_irq();
      end_frame();
      @(posedge pclk);
      stop_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      check_irq();
    end
    // A reset in mid-run must drop flags and a pending interrupt.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {m_wr, m_rd, m_pend, m_hit} = '0;
    check_irq();
    check_regs();
    set_ctrl(0, 1'b0, 1'b0, 1'b0);
    check_regs();
    summarize();
  end
endmodule // tb_top

// >>> src/mat_mailbox_tracker.sv
// Mailbox access tracker: host access flags, interrupt select, APB slave.
//
// Overview of operation
// (R1) Select 00: interrupt at end of any host packet that touched a mailbox.
// (R2) Select 00: only one interrupt per packet, however many mailboxes hit.
// (R3) Select 01: interrupt right after an access to mailbox 15 only.
// (R4) Select 10: interrupt right after an access to mailbox 31 only.
// (R5) Without read or write interrupt enable, no mailbox interrupt at all.
// (R6) Low-power enable 0: interrupt held back during STOP, asserted after.
// (R7) Thirty-two write flags, flag n belongs to mailbox n.
// (R8) Host write of a mailbox sets its write flag.
// (R9) Write-flag byte 24h holds mailboxes 31..24, bit 7 is mailbox 31.
// (R10) Write-flag byte 25h holds mailboxes 23..16, highest in bit 7.
// (R11) Write-flag byte 26h holds mailboxes 15..8, highest in bit 7.
// (R12) Write-flag byte 27h holds mailboxes 7..0, bit 0 is mailbox 0.
// (R13) CPU can read the write flags.
// (R14) Thirty-two read flags, flag n belongs to mailbox n.
// (R15) Host read of a mailbox sets its read flag.
// (R16) Read-flag byte 28h holds mailboxes 31..24, bit 7 is mailbox 31.
// (R17) CPU can read the read flags.
// (R18) Writing 1 to clear bit clears all flag bytes; bit reads zero.
// (R19) Read enable 1: host reads request an interrupt, qualified by select.
// (R20) Write enable 1: host writes request an interrupt, qualified by select.
// (R21) Low-power enable 1: interrupts asserted even during STOP.
// (R22) Reserved select 11 produces no mailbox interrupt.
// (R23) Flags stay set until clear bit or reset, CPU reads do not clear.
module mat_mailbox_tracker
  import mat_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [9:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire mat_pkg::mat_link_type link_in,
  input  wire logic              stop_mode,
  output logic                   mbox_irq
);
  import mat_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  mat_state_type st;
  mat_state_type next_st;

  logic          link_rise;
  logic          acc_evt;
  logic          qual_evt;
  logic          pkt_end;
  logic          apb_do;
  logic          clr;
  logic          set_evt;
  logic          irq_gate;
  mat_trig_type  trig;
  logic          write_irq_enable;
  logic          read_irq_enable;

  // Returns {known, data} for a register read at the given byte address.
  function automatic logic [32:0] read_decode(input logic [9:0]  a,
                                              input mat_state_type s);
    logic [32:0] r;
    r = 33'h0;
    if (a == ADDR_CTRL) begin
      r = {1'b1, 24'h0, s.ctrl & CTRL_WMASK};              // [R18]
    end else if (a == ADDR_WR_31_24) begin
      r = {1'b1, 24'h0, s.wr_flags[31:24]};                // [R9] [R13]
    end else if (a == ADDR_WR_23_16) begin
      r = {1'b1, 24'h0, s.wr_flags[23:16]};                // [R10] [R13]
    end else if (a == ADDR_WR_15_8) begin
      r = {1'b1, 24'h0, s.wr_flags[15:8]};                 // [R11] [R13]
    end else if (a == ADDR_WR_7_0) begin
      r = {1'b1, 24'h0, s.wr_flags[7:0]};                  // [R12] [R13]
    end else if (a == ADDR_RD_31_24) begin
      r = {1'b1, 24'h0, s.rd_flags[31:24]};                // [R16] [R17]
    end else if (a == ADDR_RD_23_16) begin
      r = {1'b1, 24'h0, s.rd_flags[23:16]};                // [R17]
    end else if (a == ADDR_RD_15_8) begin
      r = {1'b1, 24'h0, s.rd_flags[15:8]};                 // [R17]
    end else if (a == ADDR_RD_7_0) begin
      r = {1'b1, 24'h0, s.rd_flags[7:0]};                  // [R17]
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------------
  // Only the second and third sync stages are looked at; the link is slow
  // enough (several pclk per link period) that data settles before edges.
  assign trig      = mat_trig_type'(st.ctrl[CTRL_SEL_LSB +: 2]);
  assign write_irq_enable = st.ctrl[CTRL_WR_IRQ_EN_BIT];
  assign read_irq_enable  = st.ctrl[CTRL_RD_IRQ_EN_BIT];
  assign link_rise = st.s2.clk & ~st.s3.clk;
  assign acc_evt   = link_rise & ~st.s2.frame_n & st.s2.acc;
  assign qual_evt  = acc_evt & ((st.s2.wr & write_irq_enable)   // [R20]
                              | (~st.s2.wr & read_irq_enable)); // [R19] [R5]
  assign pkt_end   = (st.pkt == PKT_BUSY) & st.s2.frame_n;
  assign apb_do    = psel & penable & st.pready;
  assign clr       = apb_do & pwrite & (paddr == ADDR_CTRL)
                   & pwdata[CTRL_CLR_BIT];                      // [R18]
  assign irq_gate  = ~stop_mode | st.ctrl[CTRL_STOP_EN_BIT];    // [R6] [R21]

  always_comb begin
    case (trig)
      TRIG_ANY:  set_evt = pkt_end & st.hit;                    // [R1] [R2]
      TRIG_MB15: set_evt = qual_evt & (st.s2.idx == MB_FIFTEEN);    // [R3]
      TRIG_MB31: set_evt = qual_evt & (st.s2.idx == MB_THIRTY_ONE); // [R4]
      default:   set_evt = 1'b0;                                // [R22]
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [32:0] rd;
    rd = read_decode(paddr, st);
    next_st    = st;
    next_st.s1 = link_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;

    // Clearing first, then setting, so that a host access in the same
    // cycle as the clear strobe is still recorded.
    if (clr) begin                                              // [R23]
      next_st.wr_flags = 32'h0;                                 // [R18]
      next_st.rd_flags = 32'h0;                                 // [R18]
    end
    if (acc_evt && st.s2.wr) begin
      next_st.wr_flags[st.s2.idx] = 1'b1;                       // [R7] [R8]
    end
    if (acc_evt && !st.s2.wr) begin
      next_st.rd_flags[st.s2.idx] = 1'b1;                       // [R14] [R15]
    end

    if (apb_do && pwrite && (paddr == ADDR_CTRL)) begin
      next_st.ctrl = pwdata[7:0] & CTRL_WMASK;                  // [R18]
    end

    case (st.pkt)
      PKT_IDLE: begin
        if (!st.s2.frame_n) begin
          next_st.pkt = PKT_BUSY;
        end
      end
      PKT_BUSY: begin
        if (st.s2.frame_n) begin
          next_st.pkt = PKT_IDLE;
        end
      end
      default: next_st.pkt = PKT_IDLE;
    endcase

    // One hit bit per packet folds many accesses into a single event.
    if (pkt_end) begin
      next_st.hit = 1'b0;                                       // [R2]
    end else if (qual_evt) begin
      next_st.hit = 1'b1;                                       // [R1]
    end

    next_st.pending = (st.pending & ~clr) | set_evt;
    next_st.irq     = next_st.pending & irq_gate;               // [R6] [R21]

    next_st.pready  = psel & ~penable;
    next_st.pslverr = psel & ~penable & ~rd[32];
    next_st.prdata  = (psel && !penable && !pwrite) ? rd[31:0] : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign mbox_irq = st.irq;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_pkt_done;
    pkt_end && st.hit && (trig == TRIG_ANY);
  endsequence

  sequence s_mb15_acc;
    qual_evt && (st.s2.idx == MB_FIFTEEN) && (trig == TRIG_MB15);
  endsequence

  sequence s_mb31_acc;
    qual_evt && (st.s2.idx == MB_THIRTY_ONE) && (trig == TRIG_MB31);
  endsequence

  property p_any_irq;
    (s_pkt_done ##0 !stop_mode) |=> mbox_irq;
  endproperty
  a_any_irq: assert property (p_any_irq)  // [R1]
    else $error("packet end with mailbox hit did not raise interrupt");

  property p_single_per_pkt;
    (trig == TRIG_ANY && !st.pending && !pkt_end) |=> !st.pending;
  endproperty
  a_single_per_pkt: assert property (p_single_per_pkt)  // [R2]
    else $error("interrupt pending rose before packet end");

  property p_mb15_irq;
    (s_mb15_acc ##0 !stop_mode) |=> mbox_irq;
  endproperty
  a_mb15_irq: assert property (p_mb15_irq)  // [R3]
    else $error("mailbox 15 access did not raise interrupt");

  property p_mb31_irq;
    (s_mb31_acc ##0 !stop_mode) |=> mbox_irq;
  endproperty
  a_mb31_irq: assert property (p_mb31_irq)  // [R4]
    else $error("mailbox 31 access did not raise interrupt");

  property p_no_enable;
    (!read_irq_enable && !write_irq_enable && !st.hit && !st.pending)
      |=> !st.pending;
  endproperty
  a_no_enable: assert property (p_no_enable)  // [R5]
    else $error("interrupt pending with both enables off");

  property p_stop_defer;
    (stop_mode && !st.ctrl[CTRL_STOP_EN_BIT]) |=> !mbox_irq;
  endproperty
  a_stop_defer: assert property (p_stop_defer)  // [R6]
    else $error("interrupt asserted in stop without low-power enable");

  property p_stop_release;
    (st.pending && !stop_mode && !clr) |=> mbox_irq;
  endproperty
  a_stop_release: assert property (p_stop_release)  // [R6]
    else $error("pending interrupt not asserted outside stop");

  property p_wr_flag;
    (acc_evt && st.s2.wr) |=> st.wr_flags[$past(st.s2.idx)];
  endproperty
  a_wr_flag: assert property (p_wr_flag)  // [R8]
    else $error("host write did not set its write flag");

  property p_rd_flag;
    (acc_evt && !st.s2.wr) |=> st.rd_flags[$past(st.s2.idx)];
  endproperty
  a_rd_flag: assert property (p_rd_flag)  // [R15]
    else $error("host read did not set its read flag");

  property p_clear;
    (clr && !acc_evt) |=> (st.wr_flags == 32'h0) && (st.rd_flags == 32'h0);
  endproperty
  a_clear: assert property (p_clear)  // [R18]
    else $error("clear strobe left flags set");

  property p_clr_reads_zero;
    (psel && penable && pready && !pwrite && paddr == ADDR_CTRL)
      |-> !prdata[CTRL_CLR_BIT];
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero)  // [R18]
    else $error("clear bit read back as one");

  property p_stop_allow;
    (st.pending && stop_mode && st.ctrl[CTRL_STOP_EN_BIT] && !clr)
      |=> mbox_irq;
  endproperty
  a_stop_allow: assert property (p_stop_allow)  // [R21]
    else $error("interrupt not asserted in stop with low-power enable");

  property p_rsvd;
    (trig == TRIG_RSVD && !st.pending) |=> !st.pending;
  endproperty
  a_rsvd: assert property (p_rsvd)  // [R22]
    else $error("reserved select produced an interrupt");

  property p_sticky;
    !clr |=> ((st.wr_flags & $past(st.wr_flags)) == $past(st.wr_flags))
          && ((st.rd_flags & $past(st.rd_flags)) == $past(st.rd_flags));
  endproperty
  a_sticky: assert property (p_sticky)  // [R23]
    else $error("access flag fell without clear");

  // Software polls the flag bytes, so the bus answer must be a clean pulse.
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)  // [R13] [R17]
    else $error("bus ready held longer than one cycle");

  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)  // [R13] [R17]
    else $error("bus error raised without ready");

endmodule // mat_mailbox_tracker

// >>> src/mat_pkg.sv
// Constants, carrier types and state record for the mailbox access tracker.
package mat_pkg;

  // ------------------------------------------------------------------
  // Register indices; the byte address on the bus is four times these
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL         = 8'h20;
  localparam logic [7:0] IDX_WR_31_24     = 8'h24;
  localparam logic [7:0] IDX_WR_23_16     = 8'h25;
  localparam logic [7:0] IDX_WR_15_8      = 8'h26;
  localparam logic [7:0] IDX_WR_7_0       = 8'h27;
  localparam logic [7:0] IDX_RD_31_24     = 8'h28;
  localparam logic [7:0] IDX_RD_23_16     = 8'h29;
  localparam logic [7:0] IDX_RD_15_8      = 8'h2a;
  localparam logic [7:0] IDX_RD_7_0       = 8'h2b;

  localparam logic [9:0] ADDR_CTRL        = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_WR_31_24    = {IDX_WR_31_24, 2'b00};
  localparam logic [9:0] ADDR_WR_23_16    = {IDX_WR_23_16, 2'b00};
  localparam logic [9:0] ADDR_WR_15_8     = {IDX_WR_15_8, 2'b00};
  localparam logic [9:0] ADDR_WR_7_0      = {IDX_WR_7_0, 2'b00};
  localparam logic [9:0] ADDR_RD_31_24    = {IDX_RD_31_24, 2'b00};
  localparam logic [9:0] ADDR_RD_23_16    = {IDX_RD_23_16, 2'b00};
  localparam logic [9:0] ADDR_RD_15_8     = {IDX_RD_15_8, 2'b00};
  localparam logic [9:0] ADDR_RD_7_0      = {IDX_RD_7_0, 2'b00};

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int         CTRL_SEL_LSB     = 0;
  localparam int         CTRL_WR_IRQ_EN_BIT = 2;
  localparam int         CTRL_RD_IRQ_EN_BIT = 3;
  localparam int         CTRL_STOP_EN_BIT = 4;
  localparam int         CTRL_CLR_BIT     = 5;
  localparam logic [7:0] CTRL_WMASK       = 8'h1f;
  localparam logic [7:0] CTRL_RESET       = 8'h00;

  localparam logic [4:0] MB_FIFTEEN       = 5'h0f;
  localparam logic [4:0] MB_THIRTY_ONE    = 5'h1f;

  typedef enum logic [1:0] {
    TRIG_ANY  = 2'h0,
    TRIG_MB15 = 2'h1,
    TRIG_MB31 = 2'h2,
    TRIG_RSVD = 2'h3
  } mat_trig_type;

  typedef enum logic {
    PKT_IDLE = 1'b0,
    PKT_BUSY = 1'b1
  } mat_pkt_type;

  // ------------------------------------------------------------------
  // Link carrier and block state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       clk;
    logic       frame_n;
    logic       acc;
    logic       wr;
    logic [4:0] idx;
  } mat_link_type;

  localparam mat_link_type LINK_IDLE = '{clk: 1'b0, frame_n: 1'b1,
                                         acc: 1'b0, wr: 1'b0,
                                         idx: 5'h00};

  typedef struct packed {
    mat_link_type s1;
    mat_link_type s2;
    mat_link_type s3;
    logic [7:0]   ctrl;
    logic [31:0]  wr_flags;
    logic [31:0]  rd_flags;
    mat_pkt_type  pkt;
    logic         hit;
    logic         pending;
    logic         irq;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } mat_state_type;

  localparam mat_state_type ST_RESET = '{
    s1: LINK_IDLE, s2: LINK_IDLE, s3: LINK_IDLE, ctrl: CTRL_RESET,
    wr_flags: 32'h0, rd_flags: 32'h0, pkt: PKT_IDLE, hit: 1'b0,
    pending: 1'b0, irq: 1'b0, prdata: 32'h0, pready: 1'b0,
    pslverr: 1'b0};

endpackage
